// [hmpu_pkg.sv]
// Purpose: shared constants and types for the hypervisor region limit and enable block
// Assumes: one core clock, synchronous active-high reset
// Notes:   region storage is sized for 32 regions; only REGION_COUNT are implemented
//
// Notes on behaviour
// - vector bit n aliases region n enable
// - unimplemented vector bits read zero, ignore writes
// - enable bit 0; resets to disabled
// - limit bits 31:6 above six ones
// - attribute index bits 3:1 pick slot
// - indirect limit follows selector register region
// - enable vector decodes 100/0110/0001/001
// - indirect limit decodes 100/0110/0011/001
// - direct limit n decodes from n bits
// - direct limit beyond count is unallocated
// - only hypervisor level may access
// - trap bit six traps kernel indirect access
// - trap bit ten traps kernel direct access
// - selector names region for indirect registers
// - regions govern hypervisor and second stage
// - base bits 31:6 padded with zeros
package hmpu_pkg;

  // ==========================================================================
  // sizes
  localparam int NUM_REGIONS  = 32;
  localparam int REGION_COUNT = 24;
  localparam int REG_IDX_W    = 5;
  localparam int SEL_W        = 8;
  localparam int ADDR_HI_W    = 26;

  // ==========================================================================
  // instruction encodings
  localparam logic [3:0] COPROC_SYS = 4'hf;
  localparam logic [3:0] CRN_MPU    = 4'h6;
  localparam logic [2:0] OPC1_HYP   = 3'h4;
  localparam logic [3:0] CRM_ENVEC  = 4'h1;
  localparam logic [3:0] CRM_SELR   = 4'h2;
  localparam logic [3:0] CRM_LIMIT  = 4'h3;
  localparam logic [2:0] OPC2_ONE   = 3'h1;
  localparam logic [2:0] OPC2_ZERO  = 3'h0;
  localparam logic [1:0] OPC1_DIR   = 2'h0;
  localparam logic [1:0] OPC2_DIR   = 2'h0;

  // ==========================================================================
  // field layout
  localparam int LIMIT_LSB = 6;
  localparam int ATTR_MSB  = 3;
  localparam int ATTR_LSB  = 1;
  localparam int EN_BIT    = 0;
  localparam logic [5:0] LIMIT_LOW_ONES = 6'h3f;
  localparam logic [5:0] BASE_LOW_ZEROS = 6'h00;
  localparam logic [1:0] LIMIT_RES_BITS = 2'h0;
  localparam int TRAP_BIT_SIX = 6;
  localparam int TRAP_BIT_TEN = 10;

  // ==========================================================================
  // reset values
  localparam logic [ADDR_HI_W-1:0] LIMIT_RESET = 26'h0;
  localparam logic [ADDR_HI_W-1:0] BASE_RESET  = 26'h0;
  localparam logic [2:0]           ATTR_RESET  = 3'h0;
  localparam logic                 EN_RESET    = 1'b0;
  localparam logic [SEL_W-1:0]     SEL_RESET   = 8'h00;

  // ==========================================================================
  // privilege levels
  localparam logic [1:0] LEVEL_USER   = 2'h0;
  localparam logic [1:0] LEVEL_KERNEL = 2'h1;
  localparam logic [1:0] LEVEL_HYP    = 2'h2;

  typedef enum logic [2:0] {
    TGT_NONE   = 3'b000,
    TGT_ENVEC  = 3'b001,
    TGT_LIMSEL = 3'b010,
    TGT_BASSEL = 3'b011,
    TGT_SELR   = 3'b100,
    TGT_LIMDIR = 3'b101
  } hmpu_target_e;

endpackage

// [hmpu_cp_decode.sv]
// Purpose: decodes a coprocessor access into one of the block's registers
// Assumes: fields come straight from the instruction, same clock
// Notes:   purely combinational
`timescale 1ns/1ns
`default_nettype none
module hmpu_cp_decode (
  input  wire logic [3:0]           i_coproc,
  input  wire logic [2:0]           i_opc1,
  input  wire logic [3:0]           i_crn,
  input  wire logic [3:0]           i_crm,
  input  wire logic [2:0]           i_opc2,
  output var hmpu_pkg::hmpu_target_e o_target,
  output logic [4:0]                o_region
);

  logic base_ok;

  always_comb begin
    base_ok  = (i_coproc == hmpu_pkg::COPROC_SYS) && (i_crn == hmpu_pkg::CRN_MPU);
    o_target = hmpu_pkg::TGT_NONE;
    // region number of a direct access: opc1[0], crm[2:0], opc2[2]
    o_region = {i_opc1[0], i_crm[2:0], i_opc2[2]};
    if (base_ok) begin
      if (i_opc1 == hmpu_pkg::OPC1_HYP) begin
        if (i_crm == hmpu_pkg::CRM_ENVEC && i_opc2 == hmpu_pkg::OPC2_ONE) begin
          o_target = hmpu_pkg::TGT_ENVEC;
        end else if (i_crm == hmpu_pkg::CRM_LIMIT && i_opc2 == hmpu_pkg::OPC2_ONE) begin
          o_target = hmpu_pkg::TGT_LIMSEL;
        end else if (i_crm == hmpu_pkg::CRM_LIMIT && i_opc2 == hmpu_pkg::OPC2_ZERO) begin
          o_target = hmpu_pkg::TGT_BASSEL;
        end else if (i_crm == hmpu_pkg::CRM_SELR && i_opc2 == hmpu_pkg::OPC2_ONE) begin
          o_target = hmpu_pkg::TGT_SELR;
        end
      end else if (i_opc1[2:1] == hmpu_pkg::OPC1_DIR && i_crm[3]
                   && i_opc2[1:0] == hmpu_pkg::OPC2_DIR) begin
        o_target = hmpu_pkg::TGT_LIMDIR;
      end
    end
  end

endmodule
`default_nettype wire

// [hmpu_region_match.sv]
// Purpose: per-region address compare against inclusive base and limit
// Assumes: base and limit hold address bits 31:6
// Notes:   combinational; the caller registers the result
`timescale 1ns/1ns
`default_nettype none
module hmpu_region_match (
  input  wire logic [31:0]                                             i_addr,
  input  wire logic [hmpu_pkg::NUM_REGIONS-1:0][hmpu_pkg::ADDR_HI_W-1:0] i_base,
  input  wire logic [hmpu_pkg::NUM_REGIONS-1:0][hmpu_pkg::ADDR_HI_W-1:0] i_limit,
  input  wire logic [hmpu_pkg::NUM_REGIONS-1:0]                         i_enable,
  output logic [hmpu_pkg::NUM_REGIONS-1:0]                              o_match
);

  genvar g;
  generate
    for (g = 0; g < hmpu_pkg::NUM_REGIONS; g++) begin : g_reg
      logic [31:0] lo;
      logic [31:0] hi;
      assign lo = {i_base[g], hmpu_pkg::BASE_LOW_ZEROS};
      assign hi = {i_limit[g], hmpu_pkg::LIMIT_LOW_ONES};
      // both bounds inclusive, disabled regions never hit
      assign o_match[g] = i_enable[g] && (i_addr >= lo) && (i_addr <= hi);
    end
  endgenerate

endmodule
`default_nettype wire

// [hmpu_top.sv]
// Purpose: hypervisor region limit, enable vector, selector and base registers
// Assumes: at most one access per cycle; access fields stable while I_ACC_VALID
// Notes:   every access answers one cycle later with O_ACK plus one outcome
`timescale 1ns/1ns
`default_nettype none
module hmpu_top (
  input  wire logic        I_CLK,
  input  wire logic        I_RESET,
  input  wire logic        I_ACC_VALID,
  input  wire logic        I_ACC_WRITE,
  input  wire logic [3:0]  I_COPROC,
  input  wire logic [2:0]  I_OPC1,
  input  wire logic [3:0]  I_CRN,
  input  wire logic [3:0]  I_CRM,
  input  wire logic [2:0]  I_OPC2,
  input  wire logic [31:0] I_WDATA,
  input  wire logic [1:0]  I_LEVEL,
  input  wire logic        I_TGE,
  input  wire logic        I_HYP_IMPL,
  input  wire logic [31:0] I_TRAP_REG,
  input  wire logic [31:0] I_ADDR,
  output logic             O_ACK,
  output logic [31:0]      O_RDATA,
  output logic             O_UNDEF,
  output logic             O_TRAP_HYP,
  output logic [31:0]      O_MATCH
);

  localparam int NR = hmpu_pkg::NUM_REGIONS;
  localparam int AW = hmpu_pkg::ADDR_HI_W;

  // ==========================================================================
  // state
  logic [NR-1:0][AW-1:0]        limit_r, limit_nxt;
  logic [NR-1:0][AW-1:0]        base_r, base_nxt;
  logic [NR-1:0][2:0]           attr_r, attr_nxt;
  logic [NR-1:0]                en_r, en_nxt;
  logic [hmpu_pkg::SEL_W-1:0]   sel_r, sel_nxt;
  logic                         ack_r, ack_nxt;
  logic [31:0]                  rdata_r, rdata_nxt;
  logic                         undef_r, undef_nxt;
  logic                         trap_r, trap_nxt;
  logic [NR-1:0]                match_r;
  logic [NR-1:0]                match_w;
  logic [NR-1:0]                impl_mask;

  hmpu_pkg::hmpu_target_e       target;
  logic [4:0]                   dir_idx;
  logic [4:0]                   idx;
  logic                         idx_ok;
  logic                         unalloc;
  logic                         trap_bit;
  logic                         allowed;
  logic                         trapped;

  // ==========================================================================
  // decode and compare
  hmpu_cp_decode u_dec (
    .i_coproc (I_COPROC),
    .i_opc1   (I_OPC1),
    .i_crn    (I_CRN),
    .i_crm    (I_CRM),
    .i_opc2   (I_OPC2),
    .o_target (target),
    .o_region (dir_idx)
  );

  // feeds the stage-two and hypervisor access checks downstream
  hmpu_region_match u_match (
    .i_addr   (I_ADDR),
    .i_base   (base_r),
    .i_limit  (limit_r),
    .i_enable (en_r),
    .o_match  (match_w)
  );

  genvar g;
  generate
    for (g = 0; g < NR; g++) begin : g_impl
      assign impl_mask[g] = (g < hmpu_pkg::REGION_COUNT);
    end
  endgenerate

  // ==========================================================================
  // permission and trap check
  always_comb begin
    // selector can hold an unimplemented number; such accesses are dropped
    idx      = (target == hmpu_pkg::TGT_LIMDIR) ? dir_idx : sel_r[4:0];
    idx_ok   = (target == hmpu_pkg::TGT_LIMDIR) ? impl_mask[dir_idx]
             : (sel_r < hmpu_pkg::SEL_W'(hmpu_pkg::REGION_COUNT));
    unalloc  = (target == hmpu_pkg::TGT_LIMDIR) && !impl_mask[dir_idx];
    trap_bit = (target == hmpu_pkg::TGT_LIMDIR) ? I_TRAP_REG[hmpu_pkg::TRAP_BIT_TEN]
             : I_TRAP_REG[hmpu_pkg::TRAP_BIT_SIX];
    allowed  = (I_LEVEL == hmpu_pkg::LEVEL_HYP) && (target != hmpu_pkg::TGT_NONE)
               && !unalloc;
    // with general exceptions trapped the kernel level does not exist
    trapped  = (I_LEVEL == hmpu_pkg::LEVEL_KERNEL) && !I_TGE && I_HYP_IMPL
               && (target != hmpu_pkg::TGT_NONE) && !unalloc && trap_bit;
  end

  // ==========================================================================
  // register file next state
  always_comb begin
    limit_nxt = limit_r;
    base_nxt  = base_r;
    attr_nxt  = attr_r;
    en_nxt    = en_r;
    sel_nxt   = sel_r;
    rdata_nxt = 32'h0;
    ack_nxt   = I_ACC_VALID;
    trap_nxt  = I_ACC_VALID && trapped;
    undef_nxt = I_ACC_VALID && !allowed && !trapped;
    if (I_ACC_VALID && allowed) begin
      unique case (target)
        hmpu_pkg::TGT_ENVEC: begin
          if (I_ACC_WRITE) begin
            en_nxt = I_WDATA & impl_mask;
          end
          rdata_nxt = en_r & impl_mask;
        end
        hmpu_pkg::TGT_LIMSEL, hmpu_pkg::TGT_LIMDIR: begin
          if (I_ACC_WRITE && idx_ok) begin
            limit_nxt[idx] = I_WDATA[31:hmpu_pkg::LIMIT_LSB];
            attr_nxt[idx]  = I_WDATA[hmpu_pkg::ATTR_MSB:hmpu_pkg::ATTR_LSB];
            en_nxt[idx]    = I_WDATA[hmpu_pkg::EN_BIT];
          end
          if (idx_ok) begin
            rdata_nxt = {limit_r[idx], hmpu_pkg::LIMIT_RES_BITS, attr_r[idx], en_r[idx]};
          end
        end
        hmpu_pkg::TGT_BASSEL: begin
          if (I_ACC_WRITE && idx_ok) begin
            base_nxt[idx] = I_WDATA[31:hmpu_pkg::LIMIT_LSB];
          end
          if (idx_ok) begin
            rdata_nxt = {base_r[idx], hmpu_pkg::BASE_LOW_ZEROS};
          end
        end
        hmpu_pkg::TGT_SELR: begin
          if (I_ACC_WRITE) begin
            sel_nxt = I_WDATA[hmpu_pkg::SEL_W-1:0];
          end
          rdata_nxt = {24'h0, sel_r};
        end
        default: begin
          rdata_nxt = 32'h0;
        end
      endcase
    end
    // read data only on a successful read
    if (I_ACC_WRITE) begin
      rdata_nxt = 32'h0;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      limit_r <= {NR{hmpu_pkg::LIMIT_RESET}};
      base_r  <= {NR{hmpu_pkg::BASE_RESET}};
      attr_r  <= {NR{hmpu_pkg::ATTR_RESET}};
      en_r    <= {NR{hmpu_pkg::EN_RESET}};
      sel_r   <= hmpu_pkg::SEL_RESET;
      ack_r   <= 1'b0;
      rdata_r <= 32'h0;
      undef_r <= 1'b0;
      trap_r  <= 1'b0;
      match_r <= '0;
    end else begin
      limit_r <= limit_nxt;
      base_r  <= base_nxt;
      attr_r  <= attr_nxt;
      en_r    <= en_nxt;
      sel_r   <= sel_nxt;
      ack_r   <= ack_nxt;
      rdata_r <= rdata_nxt;
      undef_r <= undef_nxt;
      trap_r  <= trap_nxt;
      match_r <= match_w;
    end
  end

  assign O_ACK      = ack_r;
  assign O_RDATA    = rdata_r;
  assign O_UNDEF    = undef_r;
  assign O_TRAP_HYP = trap_r;
  assign O_MATCH    = match_r;

  // ==========================================================================
  // checks
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RESET);

  logic hyp_acc;
  logic kern_acc;
  assign hyp_acc  = I_ACC_VALID && (I_LEVEL == hmpu_pkg::LEVEL_HYP);
  assign kern_acc = I_ACC_VALID && (I_LEVEL == hmpu_pkg::LEVEL_KERNEL) && !I_TGE
                    && I_HYP_IMPL;

  envec_alias_a: assert property (
    hyp_acc && I_ACC_WRITE && target == hmpu_pkg::TGT_ENVEC
    |=> en_r == ($past(I_WDATA) & impl_mask))
    else $error("enable vector write did not reach region enables");

  unimpl_zero_a: assert property (
    ((en_r & ~impl_mask) == '0)
    and (hyp_acc && !I_ACC_WRITE && target == hmpu_pkg::TGT_ENVEC
         |=> (O_RDATA & ~impl_mask) == '0))
    else $error("unimplemented region enable is set");

  ack_one_a: assert property (
    I_ACC_VALID |=> O_ACK && !(O_UNDEF && O_TRAP_HYP))
    else $error("access not answered with a single outcome");

  idle_quiet_a: assert property (
    !I_ACC_VALID |=> !O_ACK && !O_UNDEF && !O_TRAP_HYP && O_RDATA == 32'h0)
    else $error("outcome shown without an access");

  base_write_a: assert property (
    hyp_acc && I_ACC_WRITE && target == hmpu_pkg::TGT_BASSEL
    && sel_r < 8'(hmpu_pkg::REGION_COUNT)
    |=> base_r[$past(sel_r[4:0])] == $past(I_WDATA[31:6]))
    else $error("indirect base write missed selected region");

  reset_off_a: assert property (@(posedge I_CLK)
    $past(I_RESET) |-> en_r == '0 && !O_ACK)
    else $error("regions not disabled after reset");

  limit_read_a: assert property (
    hyp_acc && !I_ACC_WRITE && target == hmpu_pkg::TGT_LIMDIR && impl_mask[dir_idx]
    |=> O_ACK && !O_UNDEF && O_RDATA[5:4] == 2'h0
        && O_RDATA[0] == $past(en_r[dir_idx]))
    else $error("direct limit read wrong");

  sel_write_a: assert property (
    hyp_acc && I_ACC_WRITE && target == hmpu_pkg::TGT_LIMSEL
    && sel_r < 8'(hmpu_pkg::REGION_COUNT)
    |=> en_r[$past(sel_r[4:0])] == $past(I_WDATA[0])
        && attr_r[$past(sel_r[4:0])] == $past(I_WDATA[3:1]))
    else $error("indirect limit write missed selected region");

  trap_six_a: assert property (
    kern_acc && I_TRAP_REG[6] && (target == hmpu_pkg::TGT_ENVEC
    || target == hmpu_pkg::TGT_LIMSEL) |=> O_ACK && O_TRAP_HYP && !O_UNDEF)
    else $error("kernel access not trapped by bit six");

  trap_ten_a: assert property (
    kern_acc && I_TRAP_REG[10] && target == hmpu_pkg::TGT_LIMDIR && impl_mask[dir_idx]
    |=> O_TRAP_HYP ##1 !O_TRAP_HYP || $past(I_ACC_VALID))
    else $error("kernel direct access not trapped by bit ten");

  user_refuse_a: assert property (
    I_ACC_VALID && I_LEVEL == hmpu_pkg::LEVEL_USER
    |=> O_UNDEF && !O_TRAP_HYP && O_RDATA == 32'h0 && en_r == $past(en_r))
    else $error("user level access not refused");

  unalloc_a: assert property (
    hyp_acc && target == hmpu_pkg::TGT_LIMDIR && !impl_mask[dir_idx]
    |=> O_UNDEF && en_r == $past(en_r) && limit_r == $past(limit_r))
    else $error("unallocated direct limit acted as storage");

  match_en_a: assert property (
    (O_MATCH & ~$past(en_r)) == '0)
    else $error("disabled region reported a match");

endmodule
`default_nettype wire

// [hmpu_core_model.sv]
// Purpose: core side issuing coprocessor register accesses
// Assumes: one access in flight, answer launched by the same edge that takes it
// Notes:   released fields are inverted so stale values never match
`timescale 1ns/1ns
`default_nettype none
module hmpu_core_model (
  input  wire logic        i_clk,
  input  wire logic        i_ack,
  input  wire logic [31:0] i_rdata,
  input  wire logic        i_undef,
  input  wire logic        i_trap,
  output logic             o_valid,
  output logic             o_write,
  output logic [17:0]      o_enc,
  output logic [31:0]      o_wdata,
  output logic [1:0]       o_level
);
  initial begin
    o_valid = 1'h0;
    o_write = 1'h0;
    o_enc   = 18'h0;
    o_wdata = 32'h0;
    o_level = 2'h0;
  end

  // ==========================================================================
  // one access: drive, hold for the taking edge, read the answer edge
  task automatic access(input logic wr, input logic [17:0] enc, input logic [31:0] wd,
                        input logic [1:0] lv, output logic [34:0] res);
    @(posedge i_clk);
    o_valid <= 1'h1;
    o_write <= wr;
    o_enc   <= enc;
    o_wdata <= wd;
    o_level <= lv;
    @(posedge i_clk);
    o_valid <= 1'h0;
    o_write <= ~wr;
    o_enc   <= ~enc;
    o_wdata <= ~wd;
    o_level <= ~lv;
    // the taking edge launches the answer; it stands only until the next edge
    #1 res = {i_ack, i_undef, i_trap, i_rdata};
  endtask
endmodule
`default_nettype wire

// [hyp_mpu_region_limit_enable_test.sv]
// Purpose: self-checking bench for the region limit and enable block
// Assumes: package sizes, answer one cycle after each access
// Notes:   expected values are built from field layout, not from the design
`timescale 1ns/1ns
`default_nettype none
module hyp_mpu_region_limit_enable_test;
  localparam logic [17:0] ENC_VEC = {4'hf, 3'h4, 4'h6, 4'h1, 3'h1};
  localparam logic [17:0] ENC_LIM = {4'hf, 3'h4, 4'h6, 4'h3, 3'h1};
  localparam logic [17:0] ENC_BAS = {4'hf, 3'h4, 4'h6, 4'h3, 3'h0};
  localparam logic [17:0] ENC_SEL = {4'hf, 3'h4, 4'h6, 4'h2, 3'h1};
  localparam logic [2:0]  OK      = 3'h4;
  localparam logic [2:0]  UND     = 3'h6;
  localparam logic [2:0]  TRP     = 3'h5;
  localparam logic [1:0]  HV      = hmpu_pkg::LEVEL_HYP;
  localparam logic [1:0]  KL      = hmpu_pkg::LEVEL_KERNEL;
  localparam logic [31:0] MASK    = (32'h1 << hmpu_pkg::REGION_COUNT) - 32'h1;
  logic        clk;
  logic        rst;
  logic        trap_general_exceptions;
  logic        impl;
  logic [31:0] trap_reg;
  logic [31:0] addr;
  logic [34:0] res;
  logic        valid;
  logic        write;
  logic [17:0] enc;
  logic [31:0] wdata;
  logic [1:0]  level;
  logic        ack;
  logic [31:0] rdata;
  logic        undef;
  logic        trap;
  logic [31:0] match;
  int          failures;
  int          checked;

  hmpu_top u_hmpu_top (.I_CLK(clk), .I_RESET(rst), .I_ACC_VALID(valid), .I_ACC_WRITE(write),
    .I_COPROC(enc[17:14]), .I_OPC1(enc[13:11]), .I_CRN(enc[10:7]), .I_CRM(enc[6:3]),
    .I_OPC2(enc[2:0]), .I_WDATA(wdata), .I_LEVEL(level), .I_TGE(trap_general_exceptions), .I_HYP_IMPL(impl),
    .I_TRAP_REG(trap_reg), .I_ADDR(addr), .O_ACK(ack), .O_RDATA(rdata), .O_UNDEF(undef),
    .O_TRAP_HYP(trap), .O_MATCH(match));
  hmpu_core_model u_hmpu_core_model (.i_clk(clk), .i_ack(ack), .i_rdata(rdata),
    .i_undef(undef), .i_trap(trap), .o_valid(valid), .o_write(write), .o_enc(enc),
    .o_wdata(wdata), .o_level(level));

  always #2 clk = ~clk;

  // ==========================================================================
  // helpers
  function automatic logic [17:0] enc_dir(input logic [4:0] n);
    return {4'hf, 2'h0, n[4], 4'h6, 1'h1, n[3:1], n[0], 2'h0};
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic xacc(input string what, input logic wr, input logic [17:0] e,
                      input logic [31:0] wd, input logic [1:0] lv,
                      input logic [2:0] fl, input logic [31:0] rd);
    u_hmpu_core_model.access(wr, e, wd, lv, res);
    check({what, " flags"}, {29'h0, res[34:32]}, {29'h0, fl});
    check({what, " data"}, res[31:0], rd);
  endtask

  // refused or trapped writes must leave state alone
  task automatic prv(input logic [1:0] lv, input logic t, input logic im,
                     input logic [31:0] tr, input logic [17:0] e, input logic [2:0] fl);
    @(posedge clk);
    trap_general_exceptions      <= t;
    impl     <= im;
    trap_reg <= tr;
    xacc("level", 1'h1, e, 32'h0, lv, fl, 32'h0);
  endtask

  // address sampled one edge, result shows the next
  task automatic mchk(input logic [31:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    repeat (2) @(posedge clk);
    #1 check("match", match, exp);
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_reset;
    xacc("vec rst", 1'h0, ENC_VEC, 32'h0, HV, OK, 32'h0);
    xacc("lim rst", 1'h0, ENC_LIM, 32'h0, HV, OK, 32'h0);
    check("match rst", match, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_alias;
    xacc("vec wr", 1'h1, ENC_VEC, 32'hffffffff, HV, OK, 32'h0);
    xacc("vec rd", 1'h0, ENC_VEC, 32'h0, HV, OK, MASK);
    xacc("dir5 en", 1'h0, enc_dir(5'h05), 32'h0, HV, OK, 32'h1);
    xacc("dir3 off", 1'h1, enc_dir(5'h03), 32'h0, HV, OK, 32'h0);
    xacc("vec rd2", 1'h0, ENC_VEC, 32'h0, HV, OK, MASK & ~32'h8);
    $display("test alias done");
  endtask

  task automatic t_direct;
    logic [31:0] wv;
    logic        im;
    for (int n = 0; n < 32; n++) begin
      wv = {26'(n * 3 + 1), 2'h3, 3'(n), 1'h1};
      im = n < hmpu_pkg::REGION_COUNT;
      xacc("dir wr", 1'h1, enc_dir(5'(n)), wv, HV, im ? OK : UND, 32'h0);
      xacc("dir rd", 1'h0, enc_dir(5'(n)), 32'h0, HV, im ? OK : UND,
           im ? wv & 32'hffffffcf : 32'h0);
    end
    xacc("vec all", 1'h0, ENC_VEC, 32'h0, HV, OK, MASK);
    $display("test direct done");
  endtask

  task automatic t_indirect;
    xacc("sel wr", 1'h1, ENC_SEL, 32'h7, HV, OK, 32'h0);
    xacc("sel rd", 1'h0, ENC_SEL, 32'h0, HV, OK, 32'h7);
    xacc("lim wr", 1'h1, ENC_LIM, 32'h123456fa, HV, OK, 32'h0);
    xacc("dir7 rd", 1'h0, enc_dir(5'h07), 32'h0, HV, OK, 32'h123456ca);
    xacc("vec rd", 1'h0, ENC_VEC, 32'h0, HV, OK, MASK & ~32'h80);
    $display("test indirect done");
  endtask

  task automatic t_priv;
    prv(hmpu_pkg::LEVEL_USER, 1'h0, 1'h1, 32'h0, ENC_VEC, UND);
    prv(2'h3, 1'h0, 1'h1, 32'h0, ENC_VEC, UND);
    prv(KL, 1'h0, 1'h1, 32'h0, ENC_VEC, UND);
    prv(KL, 1'h1, 1'h1, 32'h40, ENC_VEC, UND);
    prv(KL, 1'h0, 1'h1, 32'h40, ENC_VEC, TRP);
    prv(KL, 1'h0, 1'h1, 32'h40, ENC_LIM, TRP);
    prv(KL, 1'h0, 1'h0, 32'h40, ENC_VEC, UND);
    prv(KL, 1'h0, 1'h1, 32'h400, ENC_VEC, UND);
    prv(KL, 1'h0, 1'h1, 32'h400, enc_dir(5'h00), TRP);
    prv(KL, 1'h0, 1'h1, 32'h40, enc_dir(5'h00), UND);
    xacc("vec kept", 1'h0, ENC_VEC, 32'h0, HV, OK, MASK & ~32'h80);
    xacc("dir0 kept", 1'h0, enc_dir(5'h00), 32'h0, HV, OK, 32'h41);
    $display("test privilege done");
  endtask

  task automatic t_match;
    xacc("vec clr", 1'h1, ENC_VEC, 32'h0, HV, OK, 32'h0);
    xacc("sel 2", 1'h1, ENC_SEL, 32'h2, HV, OK, 32'h0);
    xacc("base wr", 1'h1, ENC_BAS, 32'h00001000, HV, OK, 32'h0);
    xacc("base rd", 1'h0, ENC_BAS, 32'h0, HV, OK, 32'h00001000);
    xacc("lim wr", 1'h1, ENC_LIM, 32'h00001fc1, HV, OK, 32'h0);
    mchk(32'h00000fff, 32'h0);
    mchk(32'h00001000, 32'h4);
    mchk(32'h00001fff, 32'h4);
    mchk(32'h00002000, 32'h0);
    xacc("vec off", 1'h1, ENC_VEC, 32'h0, HV, OK, 32'h0);
    mchk(32'h00001000, 32'h0);
    $display("test match done");
  endtask

  // ==========================================================================
  // run
  initial begin
    clk      = 1'h0;
    rst      = 1'h1;
    trap_general_exceptions      = 1'h0;
    impl     = 1'h1;
    trap_reg = 32'h0;
    addr     = 32'h0;
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    t_reset();
    t_alias();
    t_direct();
    t_indirect();
    t_priv();
    t_match();
    close_out();
  end

  // about 95 accesses of two cycles each; generous margin
  initial begin
    #100000;
    failures++;
    close_out();
  end
endmodule
`default_nettype wire
